/* File: modem_status_map.svh */
`ifndef MODEM_STATUS_MAP_SVH
`define MODEM_STATUS_MAP_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_STATUS    8'h08
`define OFS_CFGERR    8'h0c
`define OFS_PWD_LO    8'h10
`define OFS_PWD_HI    8'h14
`define OFS_PWD_LEN   8'h18
`define OFS_CALLER    8'h1c
`define OFS_LENCHK    8'h20
`define OFS_CHARCHK   8'h24
`define OFS_VALUE     8'h28
`define OFS_FORMAT    8'h2c
`define OFS_TXTLEN    8'h30
`define OFS_TXT0      8'h40
`define OFS_TXT3      8'h4c

// Control register fields
`define CTRL_PWD_EN   0
`define CTRL_MODBUS   1
`define CTRL_TONECHK  2
`define CTRL_MPROTO   3
`define CTRL_UCP51    5
`define CTRL_COMMA    6
`define CTRL_COMMERR  7
`define CTRL_BADCTRY  8
`define CTRL_RESET    9'h000

// Command register fields
`define CMD_SEIZE     0
`define CMD_DIAL      1
`define CMD_HANGUP    2
`define CMD_KICK      3
`define CMD_PWDCLR    4

// Status word codes
`define ERR_NONE      16'h0000
`define ERR_NOPOWER   16'h0001
`define ERR_MODEM     16'h0002
`define ERR_COUNTRY   16'h0006

// Limits
`define PWD_MAX       8
`define MSG_MAX       119
`define PHONE_MAX     40
`define AREA_LAST     8

// Timing
`define CLK_HZ        20000000
`define NT_HOLD_S     5
`define BLINK_MS      250
`define PULSE_MS      50
`define WDOG_MS       500
`define NT_HOLD_CYC   (`NT_HOLD_S * `CLK_HZ)
`define BLINK_CYC     (`BLINK_MS * (`CLK_HZ / 1000))
`define PULSE_CYC     (`PULSE_MS * (`CLK_HZ / 1000))
`define WDOG_CYC      (`WDOG_MS * (`CLK_HZ / 1000))

`endif

/* File: modem_status_pkg.sv */
package modem_status_pkg;
    typedef enum logic [1:0] {FMT_SINT, FMT_UINT, FMT_HEX} fmt_kind_t;
    typedef enum logic [1:0] {MP_NUMERIC, MP_TAP, MP_UCP} msg_proto_t;
    typedef enum logic [1:0] {LK_PWD, LK_TEXT, LK_PHONE} len_kind_t;
    typedef enum logic [1:0] {R_IDLE, R_CONV, R_EMIT} render_state_t;
endpackage

/* File: modem_status.sv */
// Operation
// - Fault LED on for power, watchdog, modem, comms
// - Good LED steady on without any fault
// - Good LED blinks on config or country error
// - Status word reports configuration error code
// - Off-hook LED on while line occupied
// - Missing tone on send lights LED if checked
// - Missing-tone LED holds about five seconds
// - Ring LED follows incoming call
// - Carrier LED on while connection lasts
// - Receive LED pulses on line receive
// - Transmit LED pulses on line transmit
// - Caller needs 1-8 char password when enabled
// - One protocol for answering and transfers
// - Numeric pages allow 0-9, A-D, asterisk
// - Text messages at most 119 characters
// - Embedded variables from nine memory areas
// - Hex values prefixed 16#, size-based digits
// - Right digits give scaled decimal point
// - Oversized value fills field with hashes
// - Comma or period separator per value (here one CTRL bit sets it for all values)
// - Dial-out numbers at most 40 characters
// - Numeric, TAP or UCP with commands 1, 51
//
// Chosen here: the register offsets and register access over Wishbone.
`include "modem_status_map.svh"

module modem_status
    import modem_status_pkg::*;
#(
    parameter int unsigned NT_HOLD_CYC = `NT_HOLD_CYC,
    parameter int unsigned BLINK_CYC   = `BLINK_CYC,
    parameter int unsigned PULSE_CYC   = `PULSE_CYC,
    parameter int unsigned WDOG_CYC    = `WDOG_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        power_ok_i,
    input  wire logic        modem_fail_i,
    input  wire logic        dial_tone_i,
    input  wire logic        ring_i,
    input  wire logic        carrier_i,
    input  wire logic        rx_busy_i,
    input  wire logic        tx_busy_i,
    output logic             module_fault_led_o,
    output logic             module_good_led_o,
    output logic             line_seized_led_o,
    output logic             dial_tone_missing_led_o,
    output logic             incoming_ring_led_o,
    output logic             carrier_present_led_o,
    output logic             rx_led_o,
    output logic             tx_led_o,
    output logic             modbus_sel_o,
    output logic             access_granted_o
);

    // ****
    // Pin synchronisers
    // ****
    localparam int NPIN = 7;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    assign pins = {tx_busy_i, rx_busy_i, carrier_i, ring_i,
                   dial_tone_i, modem_fail_i, power_ok_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                s1_ff[g] <= pins[g];
                s2_ff[g] <= s1_ff[g];
                s3_ff[g] <= s2_ff[g];
                if (rst_i) begin
                    pin_ff[g] <= (g == 0);
                end else if (s2_ff[g] == s3_ff[g]) begin
                    pin_ff[g] <= s3_ff[g];
                end
            end
        end
    endgenerate

    logic power_ok, modem_fail, tone, ring, carrier, rx_busy, tx_busy;
    assign {tx_busy, rx_busy, carrier, ring, tone, modem_fail, power_ok}
        = pin_ff;

    // ****
    // Wishbone slave
    // ****
    logic        ack_ff;
    logic [31:0] rdata;
    logic        wr;
    logic [31:0] wmask;
    assign wr    = cyc_i & stb_i & we_i & ack_ff;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                    {8{sel_i[0]}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_o  <= 32'h0;
        end else begin
            ack_ff <= cyc_i & stb_i & ~ack_ff;
            if (cyc_i & stb_i & ~ack_ff & ~we_i) begin
                dat_o <= rdata;
            end
        end
    end
    assign ack_o = ack_ff;

    function automatic logic hit(input logic [7:0] ofs);
        hit = wr && (adr_i == ofs);
    endfunction

    // ****
    // Control, commands and status word
    // ****
    logic [8:0]  ctrl_ff;
    logic [15:0] cfgerr_ff;
    logic [15:0] status_word;
    logic        cfg_bad;
    logic [31:0] cmd;
    assign cmd = (wr && adr_i == `OFS_CMD) ? (dat_i & wmask) : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (hit(`OFS_CTRL)) begin
            ctrl_ff <= (ctrl_ff & ~wmask[8:0]) | (dat_i[8:0] & wmask[8:0]);
        end
    end
    assign modbus_sel_o = ctrl_ff[`CTRL_MODBUS];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfgerr_ff <= `ERR_NONE;
        end else if (hit(`OFS_CFGERR)) begin
            cfgerr_ff <= (cfgerr_ff & ~wmask[15:0])
                       | (dat_i[15:0] & wmask[15:0]);
        end
    end

    always_comb begin
        if (!power_ok) begin
            status_word = `ERR_NOPOWER;
        end else if (modem_fail) begin
            status_word = `ERR_MODEM;
        end else if (ctrl_ff[`CTRL_BADCTRY]) begin
            status_word = `ERR_COUNTRY;
        end else begin
            status_word = cfgerr_ff;
        end
    end
    assign cfg_bad = (cfgerr_ff != `ERR_NONE) | ctrl_ff[`CTRL_BADCTRY];

    // ****
    // Watchdog, fault and good indicators
    // ****
    logic [31:0] wdog_ff;
    logic        wdog_to_ff;
    logic [31:0] blink_cnt_ff;
    logic        blink_ff;
    logic        fault;

    always_ff @(posedge clk_i) begin
        if (rst_i || cmd[`CMD_KICK]) begin
            wdog_ff    <= 32'h0;
            wdog_to_ff <= 1'b0;
        end else if (wdog_ff >= WDOG_CYC - 1) begin
            wdog_to_ff <= 1'b1;
        end else begin
            wdog_ff <= wdog_ff + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_ff <= 32'h0;
            blink_ff     <= 1'b0;
        end else if (blink_cnt_ff >= BLINK_CYC - 1) begin
            blink_cnt_ff <= 32'h0;
            blink_ff     <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
        end
    end

    assign fault = ~power_ok | wdog_to_ff | modem_fail
                 | ctrl_ff[`CTRL_COMMERR];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_fault_led_o <= 1'b0;
            module_good_led_o  <= 1'b0;
        end else begin
            module_fault_led_o <= fault;
            module_good_led_o  <= ~fault
                                & (~cfg_bad | blink_ff);
        end
    end

    // ****
    // Line state indicators
    // ****
    logic [31:0] nt_cnt_ff;
    logic        seized_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || cmd[`CMD_HANGUP]) begin
            seized_ff <= 1'b0;
        end else if (cmd[`CMD_SEIZE] || carrier) begin
            seized_ff <= 1'b1;
        end else if (cmd[`CMD_DIAL]) begin
            seized_ff <= tone | ~ctrl_ff[`CTRL_TONECHK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nt_cnt_ff <= 32'h0;
        end else if (cmd[`CMD_DIAL] && !tone && ctrl_ff[`CTRL_TONECHK]) begin
            nt_cnt_ff <= NT_HOLD_CYC;
        end else if (nt_cnt_ff != 32'h0) begin
            nt_cnt_ff <= nt_cnt_ff - 32'h1;
        end
    end

    logic [31:0] rx_cnt_ff, tx_cnt_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_cnt_ff <= 32'h0;
            tx_cnt_ff <= 32'h0;
        end else begin
            rx_cnt_ff <= rx_busy ? PULSE_CYC
                       : (rx_cnt_ff != 32'h0) ? rx_cnt_ff - 32'h1 : 32'h0;
            tx_cnt_ff <= tx_busy ? PULSE_CYC
                       : (tx_cnt_ff != 32'h0) ? tx_cnt_ff - 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_seized_led_o       <= 1'b0;
            dial_tone_missing_led_o <= 1'b0;
            incoming_ring_led_o     <= 1'b0;
            carrier_present_led_o   <= 1'b0;
            rx_led_o                <= 1'b0;
            tx_led_o                <= 1'b0;
        end else begin
            line_seized_led_o       <= seized_ff;
            dial_tone_missing_led_o <= nt_cnt_ff != 32'h0;
            incoming_ring_led_o     <= ring;
            carrier_present_led_o   <= carrier;
            rx_led_o                <= rx_cnt_ff != 32'h0;
            tx_led_o                <= tx_cnt_ff != 32'h0;
        end
    end

    // ****
    // Password check
    // ****
    logic [63:0] pwd_ff;
    logic [3:0]  pwd_len_ff;
    logic [3:0]  caller_cnt_ff;
    logic        caller_bad_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwd_ff     <= 64'h0;
            pwd_len_ff <= 4'h0;
        end else begin
            if (hit(`OFS_PWD_LO)) pwd_ff[31:0]  <= dat_i;
            if (hit(`OFS_PWD_HI)) pwd_ff[63:32] <= dat_i;
            if (hit(`OFS_PWD_LEN)) pwd_len_ff <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || cmd[`CMD_PWDCLR] || !carrier) begin
            caller_cnt_ff    <= 4'h0;
            caller_bad_ff    <= 1'b0;
            access_granted_o <= 1'b0;
        end else if (!ctrl_ff[`CTRL_PWD_EN]) begin
            access_granted_o <= 1'b1;
        end else if (hit(`OFS_CALLER)) begin
            if (dat_i[8]) begin
                access_granted_o <= !caller_bad_ff
                    && caller_cnt_ff == pwd_len_ff
                    && pwd_len_ff != 4'h0
                    && pwd_len_ff <= 4'(`PWD_MAX);
                caller_cnt_ff <= 4'h0;
                caller_bad_ff <= 1'b0;
            end else begin
                if (caller_cnt_ff >= 4'(`PWD_MAX) ||
                    pwd_ff[8*caller_cnt_ff[2:0] +: 8] != dat_i[7:0]) begin
                    caller_bad_ff <= 1'b1;
                end
                if (caller_cnt_ff != 4'hf) begin
                    caller_cnt_ff <= caller_cnt_ff + 4'h1;
                end
            end
        end
    end

    // ****
    // Length and character checks
    // ****
    logic len_ok_ff, char_ok_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_ok_ff  <= 1'b0;
            char_ok_ff <= 1'b0;
        end else begin
            if (hit(`OFS_LENCHK)) begin
                case (len_kind_t'(dat_i[9:8]))
                    LK_PWD:   len_ok_ff <= dat_i[7:0] >= 8'd1 &&
                                           dat_i[7:0] <= 8'(`PWD_MAX);
                    LK_TEXT:  len_ok_ff <= dat_i[7:0] <= 8'(`MSG_MAX);
                    LK_PHONE: len_ok_ff <= dat_i[7:0]
                                        <= 8'(`PHONE_MAX);
                    default:  len_ok_ff <= 1'b0;
                endcase
            end
            if (hit(`OFS_CHARCHK)) begin
                if (msg_proto_t'(ctrl_ff[4:3]) == MP_NUMERIC) begin
                    char_ok_ff <= (dat_i[7:0] >= 8'h30 && dat_i[7:0] <= 8'h39)
                        || (dat_i[7:0] >= 8'h41 && dat_i[7:0] <= 8'h44)
                        || dat_i[7:0] == 8'h2a;
                end else begin
                    char_ok_ff <= dat_i[7:0] >= 8'h20 && dat_i[7:0] <= 8'h7e;
                end
            end
        end
    end

    // ****
    // Embedded value renderer
    // ****
    render_state_t st_ff;
    logic [15:0] fmt_ff;
    logic [31:0] val_ff, bin_ff;
    logic [39:0] bcd_ff, bcd_adj;
    logic [5:0]  step_ff;
    logic        neg_ff, ovf_ff, area_err_ff;
    logic [4:0]  txt_len_ff;
    logic [7:0]  txt_ff [16];
    logic [7:0]  nxt_txt [16];
    logic [4:0]  nxt_len;
    logic        nxt_ovf;
    logic [31:0] sized;
    fmt_kind_t   kind;
    logic [3:0]  left_d, right_d;
    assign kind    = fmt_kind_t'(fmt_ff[1:0]);
    assign left_d  = fmt_ff[7:4];
    assign right_d = fmt_ff[11:8];

    always_comb begin
        case (fmt_ff[3:2])
            2'd0:    sized = {{24{kind == FMT_SINT && dat_i[7]}}, dat_i[7:0]};
            2'd1:    sized = {{16{kind == FMT_SINT && dat_i[15]}}, dat_i[15:0]};
            default: sized = dat_i;
        endcase
    end

    generate
        for (g = 0; g < 10; g++) begin : g_dabble
            assign bcd_adj[4*g +: 4] = (bcd_ff[4*g +: 4] >= 4'd5)
                ? bcd_ff[4*g +: 4] + 4'd3 : bcd_ff[4*g +: 4];
        end
    endgenerate

    always_comb begin
        int w, hlen, nd, need, d;
        w = int'(left_d) + int'(right_d) + ((right_d != 4'h0) ? 1 : 0);
        if (w > 16) w = 16;
        hlen = 3 + ((fmt_ff[3:2] == 2'd0) ? 2 : (fmt_ff[3:2] == 2'd1) ? 4 : 8);
        nd = 1;
        need = 0;
        d = 0;
        for (int i = 0; i < 16; i++) nxt_txt[i] = 8'h20;
        for (int i = 1; i < 10; i++) begin
            if (bcd_ff[4*i +: 4] != 4'h0) nd = i + 1;
        end
        nxt_ovf = 1'b0;
        if (kind == FMT_HEX) begin
            nxt_len = 5'(hlen);
            for (int i = 0; i < 16; i++) begin
                if (i == 0) nxt_txt[i] = 8'h31;
                else if (i == 1) nxt_txt[i] = 8'h36;
                else if (i == 2) nxt_txt[i] = 8'h23;
                else if (i < hlen) begin
                    d = int'(val_ff[4*(hlen-1-i) +: 4]);
                    nxt_txt[i] = 8'((d < 10) ? 48 + d : 55 + d);
                end
            end
        end else begin
            nxt_len = 5'(w);
            need = ((nd > int'(right_d)) ? nd : int'(right_d) + 1)
                 + ((right_d != 4'h0) ? 1 : 0) + (neg_ff ? 1 : 0);
            if (need > w) begin
                nxt_ovf = 1'b1;
                for (int i = 0; i < 16; i++) begin
                    if (i < w) nxt_txt[i] = 8'h23;
                end
            end else begin
                for (int k = 0; k < 16; k++) begin
                    d = k - ((right_d != 4'h0 && k > int'(right_d)) ? 1 : 0);
                    if (k < w) begin
                        if (right_d != 4'h0 && k == int'(right_d)) begin
                            nxt_txt[w-1-k] = ctrl_ff[`CTRL_COMMA]
                                ? 8'h2c : 8'h2e;
                        end else if (d < nd || d <= int'(right_d)) begin
                            nxt_txt[w-1-k] = {4'h3, bcd_ff[4*(d%10) +: 4]};
                        end else if (neg_ff && d == need - 1
                                     - ((right_d != 4'h0) ? 1 : 0)) begin
                            nxt_txt[w-1-k] = 8'h2d;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff       <= R_IDLE;
            fmt_ff      <= 16'h0;
            val_ff      <= 32'h0;
            bin_ff      <= 32'h0;
            bcd_ff      <= 40'h0;
            step_ff     <= 6'h0;
            neg_ff      <= 1'b0;
            ovf_ff      <= 1'b0;
            area_err_ff <= 1'b0;
            txt_len_ff  <= 5'h0;
            for (int i = 0; i < 16; i++) txt_ff[i] <= 8'h20;
        end else begin
            case (st_ff)
                R_IDLE: begin
                    if (hit(`OFS_FORMAT)) fmt_ff <= dat_i[15:0];
                    if (hit(`OFS_VALUE)) begin
                        val_ff  <= sized;
                        neg_ff  <= kind == FMT_SINT && sized[31];
                        bin_ff  <= (kind == FMT_SINT && sized[31])
                                 ? 32'h0 - sized : sized;
                        bcd_ff  <= 40'h0;
                        step_ff <= 6'h0;
                        area_err_ff <= fmt_ff[15:12]
                                     > 4'(`AREA_LAST);
                        st_ff   <= R_CONV;
                    end
                end
                R_CONV: begin
                    {bcd_ff, bin_ff} <= {bcd_adj, bin_ff} << 1;
                    step_ff <= step_ff + 6'h1;
                    if (step_ff == 6'd31) st_ff <= R_EMIT;
                end
                R_EMIT: begin
                    for (int i = 0; i < 16; i++) txt_ff[i] <= nxt_txt[i];
                    txt_len_ff <= nxt_len;
                    ovf_ff     <= nxt_ovf;
                    st_ff      <= R_IDLE;
                end
                default: st_ff <= R_IDLE;
            endcase
        end
    end

    // ****
    // Read mux
    // ****
    always_comb begin
        rdata = 32'h0;
        if (adr_i == `OFS_CTRL) begin
            rdata = {23'h0, ctrl_ff};
        end else if (adr_i == `OFS_STATUS) begin
            rdata = {19'h0, wdog_to_ff, char_ok_ff, len_ok_ff,
                     st_ff != R_IDLE, access_granted_o,
                     tx_led_o, rx_led_o, carrier_present_led_o,
                     incoming_ring_led_o, dial_tone_missing_led_o,
                     line_seized_led_o, module_good_led_o,
                     module_fault_led_o};
        end else if (adr_i == `OFS_CFGERR) begin
            rdata = {16'h0, status_word};
        end else if (adr_i == `OFS_PWD_LEN) begin
            rdata = {28'h0, pwd_len_ff};
        end else if (adr_i == `OFS_FORMAT) begin
            rdata = {16'h0, fmt_ff};
        end else if (adr_i == `OFS_TXTLEN) begin
            rdata = {25'h0, area_err_ff, ovf_ff, txt_len_ff};
        end else if (adr_i >= `OFS_TXT0 && adr_i <= `OFS_TXT3
                     && adr_i[1:0] == 2'b00) begin
            rdata = {txt_ff[{adr_i[3:2], 2'd3}], txt_ff[{adr_i[3:2], 2'd2}],
                     txt_ff[{adr_i[3:2], 2'd1}], txt_ff[{adr_i[3:2], 2'd0}]};
        end
    end

    // Sender reads protocol and UCP command from CTRL

endmodule

/* File: modem_status_sva.sv */
// ****
// Bus timing and indicator checks
// ****
module modem_status_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic power_ok_i,
    input wire logic ring_i,
    input wire logic carrier_i,
    input wire logic tx_busy_i,
    input wire logic module_fault_led_o,
    input wire logic line_seized_led_o,
    input wire logic dial_tone_missing_led_o,
    input wire logic incoming_ring_led_o,
    input wire logic carrier_present_led_o,
    input wire logic tx_led_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_lost; !power_ok_i [*6]; endsequence
    property p_ack; s_req |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack_one; ack_o |=> !ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_fault; s_lost |=> module_fault_led_o; endproperty
    a_fault: assert property (p_fault) else $error("fault dark");
    property p_seized; carrier_i [*6] |=> line_seized_led_o; endproperty
    a_seized: assert property (p_seized) else $error("hook dark");
    property p_hold; $rose(dial_tone_missing_led_o)
        |-> dial_tone_missing_led_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("tone short");
    property p_ring; ring_i [*6] |=> incoming_ring_led_o; endproperty
    a_ring: assert property (p_ring) else $error("ring dark");
    property p_cd; carrier_i [*6] |=> carrier_present_led_o; endproperty
    a_cd: assert property (p_cd) else $error("carrier dark");
    property p_tx; tx_busy_i [*6] |=> tx_led_o; endproperty
    a_tx: assert property (p_tx) else $error("tx dark");
endmodule

bind modem_status modem_status_sva u_sva (.*);

/* File: modem_line_model.sv */
// ****
// Line side: supply, modem and caller
// ****
module modem_line_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [5:0] want_i,
    output logic            power_ok_o,
    output logic            modem_fail_o,
    output logic            dial_tone_o,
    output logic            ring_o,
    output logic            carrier_o,
    output logic            rx_busy_o,
    output logic            tx_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    always_ff @(posedge clk_i) cnt_ff <= rst_i ? 4'h0 : cnt_ff + 4'h1;
    assign {ring_o, dial_tone_o, modem_fail_o, power_ok_o} = want_i[3:0];
    assign carrier_o = want_i[4];
    // Data only while connected, directions take turns
    assign rx_busy_o = want_i[5] & carrier_o & cnt_ff[3];
    assign tx_busy_o = want_i[5] & carrier_o & ~cnt_ff[3];
endmodule

/* File: test_modem_status.sv */
// ****
// Status, limits and renderer bench
// ****
module test_modem_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, ack_o;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [5:0]  want = 6'h05;
    logic        power_ok_i, modem_fail_i, dial_tone_i, ring_i, carrier_i;
    logic        rx_busy_i, tx_busy_i, modbus_sel_o, access_granted_o;
    logic        module_fault_led_o, module_good_led_o, line_seized_led_o;
    logic        dial_tone_missing_led_o, incoming_ring_led_o;
    logic        carrier_present_led_o, rx_led_o, tx_led_o;
    int          n_errors = 0, tests_run = 0, n;
    wire  [7:0]  leds = {module_fault_led_o, module_good_led_o,
        line_seized_led_o, dial_tone_missing_led_o, incoming_ring_led_o,
        carrier_present_led_o, rx_led_o, tx_led_o};
    logic [11:0] lens [8] = '{12'h977, 12'h178, 12'ha28, 12'h229,
                              12'h808, 12'h009, 12'h000, 12'h801};
    logic [9:0]  chars [6] = '{10'h12a, 10'h144, 10'h045, 10'h139,
                               10'h023, 10'h345};
    modem_status #(.NT_HOLD_CYC(50), .BLINK_CYC(8), .PULSE_CYC(5),
                   .WDOG_CYC(20000)) dut (.*);
    modem_line_model u_line (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
        .power_ok_o(power_ok_i), .modem_fail_o(modem_fail_i),
        .dial_tone_o(dial_tone_i), .ring_o(ring_i), .carrier_o(carrier_i),
        .rx_busy_o(rx_busy_i), .tx_busy_o(tx_busy_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Loads format and value, waits out the renderer, reads the length
    task automatic render(input logic [15:0] f, input logic [31:0] v);
        wb(1'b1, 8'h2c, {16'h0, f});
        wb(1'b1, 8'h28, v);
        wb(1'b0, 8'h08, 0);
        for (int j = 0; j < 40 && q[9] !== 1'b0; j++) begin
            wb(1'b0, 8'h08, 0);
        end
        chk(q[9], 1'b0);
        wb(1'b0, 8'h30, 0);
    endtask
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(leds, 8'h40);
        wb(1'b0, 8'h08, 0);
        chk(q[7:0], 8'h02);
        wb(1'b0, 8'h3c, 0);
        chk(q, 32'h0);
        wb(1'b1, 8'h00, 32'h2);
        wb(1'b0, 8'h00, 0);
        chk({q[8:0], modbus_sel_o}, 10'h005);
        wb(1'b1, 8'h0c, 32'h5);
        n = 0;
        repeat (16) begin
            @(posedge clk_i);
            n += !module_good_led_o;
        end
        chk(n, 8);
        wb(1'b0, 8'h0c, 0);
        chk(q[15:0], 16'h5);
        wb(1'b1, 8'h0c, 0);
        wb(1'b1, 8'h00, 32'h100);
        wb(1'b0, 8'h0c, 0);
        chk(q[15:0], 16'h6);
        wb(1'b1, 8'h00, 0);
        for (int i = 0; i < 2; i++) begin
            want <= i ? 6'h07 : 6'h04;
            repeat (8) @(posedge clk_i);
            wb(1'b0, 8'h0c, 0);
            chk({leds[7:6], q[15:0]}, {2'b10, 16'(i + 1)});
        end
        want <= 6'h01;
        wb(1'b1, 8'h00, 32'h4);
        repeat (6) @(posedge clk_i);
        wb(1'b1, 8'h04, 32'h2);
        @(posedge clk_i);
        n = 0;
        while (dial_tone_missing_led_o !== 1'b0 && n < 99) begin
            @(posedge clk_i);
            n++;
        end
        chk(n inside {[48:52]}, 1'b1);
        wb(1'b1, 8'h00, 0);
        wb(1'b1, 8'h04, 32'h2);
        repeat (3) @(posedge clk_i);
        chk(dial_tone_missing_led_o, 1'b0);
        wb(1'b1, 8'h04, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(line_seized_led_o, 1'b1);
        wb(1'b1, 8'h04, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(line_seized_led_o, 1'b0);
        want <= 6'h3d;
        repeat (24) @(posedge clk_i);
        n = 0;
        repeat (16) begin
            @(posedge clk_i);
            n += rx_led_o + tx_led_o;
        end
        chk(n, 24);
        chk(access_granted_o, 1'b1);
        chk({leds[5], leds[3:2]}, 3'b111);
        want <= 6'h05;
        repeat (40) @(posedge clk_i);
        chk(leds[3:0], 4'h0);
        foreach (lens[i]) begin
            wb(1'b1, 8'h20, {22'h0, lens[i][9:0]});
            wb(1'b0, 8'h08, 0);
            chk(q[10], lens[i][11]);
        end
        foreach (chars[i]) begin
            wb(1'b1, 8'h00, {28'h0, chars[i][9], 3'h0});
            wb(1'b1, 8'h24, {24'h0, chars[i][7:0]});
            wb(1'b0, 8'h08, 0);
            chk(q[11], chars[i][8]);
        end
        render(16'h0006, 32'h123);
        chk(q[6:0], 7'h07);
        wb(1'b0, 8'h40, 0);
        chk(q, 32'h30233631);
        wb(1'b0, 8'h44, 0);
        chk(q[23:0], 24'h333231);
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, 8'h00, {25'h0, i[0], 6'h0});
            render(16'h0224, 32'd1234);
            wb(1'b0, 8'h40, 0);
            chk(q, i ? 32'h332c3231 : 32'h332e3231);
        end
        render(16'h0011, 32'd99);
        chk(q[6:0], 7'h21);
        wb(1'b0, 8'h40, 0);
        chk(q[15:0], 16'h2023);
        render(16'h9006, 32'h1);
        chk(q[6], 1'b1);
        repeat (20000) @(posedge clk_i);
        chk(module_fault_led_o, 1'b1);
        wb(1'b1, 8'h04, 32'h8);
        repeat (8) @(posedge clk_i);
        chk(module_fault_led_o, 1'b0);
        wrap_up();
    end
endmodule
